// ===== design/rsws_top.sv
// Regulator sleep/wake sequencer with APB register access.
// Assumes feedback, frequency and reference words are synchronous to CLK;
// the open-loop switch and run command are pins and get synchronised.
`timescale 1ns/1ps
`default_nettype none
module rsws_top
  import rsws_pkg::*;
(
  input  wire logic             CLK,
  input  wire logic             RST_N,
  input  wire logic             PSEL,
  input  wire logic             PENABLE,
  input  wire logic             PWRITE,
  input  wire logic [11:0]      PADDR,
  input  wire logic [31:0]      PWDATA,
  output logic      [31:0]      PRDATA,
  output logic                  PREADY,
  output logic                  PSLVERR,
  input  wire logic             RUN_CMD,
  input  wire logic             OPEN_LOOP_SWITCH,
  input  wire logic [VAL_W-1:0] FEEDBACK,
  input  wire logic [VAL_W-1:0] REFERENCE,
  input  wire logic [VAL_W-1:0] OUTPUT_FREQ,
  output logic                  REGULATION_EN,
  output logic                  OPEN_LOOP_EN,
  output logic [VAL_W-1:0]      OPEN_LOOP_TARGET,
  output logic                  OUTPUT_BLOCK,
  output logic                  PRE_REGULATION_FAILURE_TRIP,
  output logic                  SLEEP_WARNING,
  output logic                  IRQ
);
  function automatic logic sync_agree(input logic [2:0] s, input logic cur);
    sync_agree = (s[1] == s[2]) ? s[2] : cur;
  endfunction

  logic [2:0] run_sync_reg;
  logic [2:0] olsw_sync_reg;
  logic       run_reg;
  logic       run_next;
  logic       olsw_reg;
  logic       olsw_next;

  always_comb begin
    run_next  = sync_agree(run_sync_reg, run_reg);
    olsw_next = sync_agree(olsw_sync_reg, olsw_reg);
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      run_sync_reg  <= 3'h0;
      olsw_sync_reg <= 3'h0;
      run_reg       <= 1'b0;
      olsw_reg      <= 1'b0;
    end else begin
      run_sync_reg  <= {run_sync_reg[1:0], RUN_CMD};
      olsw_sync_reg <= {olsw_sync_reg[1:0], OPEN_LOOP_SWITCH};
      run_reg       <= run_next;
      olsw_reg      <= olsw_next;
    end
  end

  // Registers
  logic [1:0]       wmode_reg, wmode_next;
  logic [VAL_W-1:0] prefreq_reg, prefreq_next;
  logic [VAL_W-1:0] preexit_reg, preexit_next;
  logic [DLY_W-1:0] predly_reg, predly_next;
  logic [DLY_W-1:0] slpdly_reg, slpdly_next;
  logic [VAL_W-1:0] slpfreq_reg, slpfreq_next;
  logic [VAL_W-1:0] wakelev_reg, wakelev_next;
  logic [IRQ_W-1:0] istat_reg, istat_next;
  logic [IRQ_W-1:0] imask_reg, imask_next;
  logic [31:0]      prdata_reg, prdata_next;
  logic             fault_clr;
  logic [IRQ_W-1:0] events;

  logic wr_acc;
  logic rd_acc;
  logic addr_ok;
  assign wr_acc = PSEL && PENABLE && PWRITE;
  assign rd_acc = PSEL && PENABLE && !PWRITE;

  always_comb begin
    case (PADDR)
      CTRL_OFS, PREFREQ_OFS, PREEXIT_OFS, PREDLY_OFS, SLPDLY_OFS,
      SLPFREQ_OFS, WAKELEV_OFS, STATE_OFS, IRQ_STAT_OFS,
      IRQ_MASK_OFS: addr_ok = 1'b1;
      default: addr_ok = 1'b0;
    endcase
  end

  // Zero wait: read data loads in setup so it stands at the access edge
  assign PREADY  = 1'b1;
  assign PSLVERR = PSEL && PENABLE && !addr_ok;
  assign PRDATA  = prdata_reg;

  rsws_state_t state_reg, state_next;

  always_comb begin
    wmode_next   = wmode_reg;
    prefreq_next = prefreq_reg;
    preexit_next = preexit_reg;
    predly_next  = predly_reg;
    slpdly_next  = slpdly_reg;
    slpfreq_next = slpfreq_reg;
    wakelev_next = wakelev_reg;
    imask_next   = imask_reg;
    prdata_next  = prdata_reg;
    fault_clr    = 1'b0;
    istat_next   = istat_reg;
    if (wr_acc) begin
      case (PADDR)
        CTRL_OFS: begin
          wmode_next = PWDATA[CTRL_WMODE_LSB +: 2];
          fault_clr  = PWDATA[CTRL_FCLR_BIT];
        end
        PREFREQ_OFS:  prefreq_next = PWDATA[VAL_W-1:0];
        PREEXIT_OFS:  preexit_next = PWDATA[VAL_W-1:0];
        PREDLY_OFS:   predly_next  = PWDATA[DLY_W-1:0];
        SLPDLY_OFS:   slpdly_next  = PWDATA[DLY_W-1:0];
        SLPFREQ_OFS:  slpfreq_next = PWDATA[VAL_W-1:0];
        WAKELEV_OFS:  wakelev_next = PWDATA[VAL_W-1:0];
        IRQ_MASK_OFS: imask_next   = PWDATA[IRQ_W-1:0];
        default: ;
      endcase
    end
    if (PSEL && !PENABLE && !PWRITE) begin
      case (PADDR)
        CTRL_OFS:     prdata_next = {30'h0, wmode_reg};
        PREFREQ_OFS:  prdata_next = {16'h0, prefreq_reg};
        PREEXIT_OFS:  prdata_next = {16'h0, preexit_reg};
        PREDLY_OFS:   prdata_next = {16'h0, predly_reg};
        SLPDLY_OFS:   prdata_next = {16'h0, slpdly_reg};
        SLPFREQ_OFS:  prdata_next = {16'h0, slpfreq_reg};
        WAKELEV_OFS:  prdata_next = {16'h0, wakelev_reg};
        STATE_OFS:    prdata_next = {26'h0, state_reg};
        IRQ_STAT_OFS: prdata_next = {29'h0, istat_reg};
        IRQ_MASK_OFS: prdata_next = {29'h0, imask_reg};
        default:      prdata_next = 32'h0;
      endcase
    end
    if (rd_acc && PADDR == IRQ_STAT_OFS) begin
      istat_next = istat_reg & ~prdata_reg[IRQ_W-1:0];
    end
    // A new event in the clearing cycle survives
    istat_next = istat_next | events;
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      wmode_reg   <= WAKE_BELOW;
      prefreq_reg <= PREFREQ_RST;
      preexit_reg <= PREEXIT_RST;
      predly_reg  <= PREDLY_RST;
      slpdly_reg  <= SLPDLY_RST;
      slpfreq_reg <= SLPFREQ_RST;
      wakelev_reg <= WAKELEV_RST;
      istat_reg   <= '0;
      imask_reg   <= '0;
      prdata_reg  <= 32'h0;
    end else begin
      wmode_reg   <= wmode_next;
      prefreq_reg <= prefreq_next;
      preexit_reg <= preexit_next;
      predly_reg  <= predly_next;
      slpdly_reg  <= slpdly_next;
      slpfreq_reg <= slpfreq_next;
      wakelev_reg <= wakelev_next;
      istat_reg   <= istat_next;
      imask_reg   <= imask_next;
      prdata_reg  <= prdata_next;
    end
  end

  assign IRQ = |(istat_reg & imask_reg);

  // Millisecond tick shared by both timers
  logic [TICK_W-1:0] tick_reg, tick_next;
  logic              tick;
  assign tick = (tick_reg == TICK_W'(TICK_CYC - 1));
  always_comb begin
    tick_next = tick ? '0 : tick_reg + 15'h0001;
  end
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      tick_reg <= '0;
    end else begin
      tick_reg <= tick_next;
    end
  end

  // Sequencer
  logic fb_high;
  logic slow;
  logic wake;
  logic pre_run;
  logic slp_run;
  logic pre_exp;
  logic slp_exp;
  logic [VAL_W:0] err;

  assign fb_high = FEEDBACK > preexit_reg;
  assign slow    = OUTPUT_FREQ < slpfreq_reg;
  assign err     = {1'b0, REFERENCE} - {1'b0, FEEDBACK};

  always_comb begin
    case (wmode_reg)
      WAKE_BELOW:  wake = FEEDBACK < wakelev_reg; // R7
      WAKE_ABOVE:  wake = FEEDBACK > wakelev_reg; // R8
      WAKE_BEYOND: wake = !err[VAL_W] &&
                          (err[VAL_W-1:0] > wakelev_reg); // R9
      default:     wake = 1'b0;
    endcase
  end

  // Zero fail delay disables the check; open-loop clears its count
  assign pre_run = (state_reg == RSWS_PRE) && !fb_high &&
                   (predly_reg != '0) && !olsw_reg; // R4 R13
  assign slp_run = (state_reg == RSWS_REG) && slow && !olsw_reg; // R5 R13

  rsws_timer u_pre_timer (
    .clk     (CLK),
    .rst_n   (RST_N),
    .tick    (tick),
    .run     (pre_run),
    .limit   (predly_reg),
    .expired (pre_exp)
  );

  rsws_timer u_slp_timer (
    .clk     (CLK),
    .rst_n   (RST_N),
    .tick    (tick),
    .run     (slp_run),
    .limit   (slpdly_reg),
    .expired (slp_exp)
  );

  logic regulating_reg, regulating_next;

  always_comb begin
    state_next      = state_reg;
    regulating_next = regulating_reg;
    events          = '0;
    case (state_reg)
      RSWS_IDLE: begin
        regulating_next = 1'b0;
        if (run_reg) begin
          state_next = olsw_reg ? RSWS_OPEN : RSWS_PRE; // R1 R10
        end
      end
      RSWS_PRE: begin
        if (!run_reg) begin
          state_next = RSWS_IDLE;
        end else if (olsw_reg) begin
          state_next = RSWS_OPEN; // R10
        end else if (fb_high) begin
          state_next      = RSWS_REG; // R3
          regulating_next = 1'b1;
        end else if (pre_exp) begin
          state_next = RSWS_TRIP; // R4
          events[IRQ_TRIP_BIT] = 1'b1;
        end
      end
      RSWS_REG: begin
        if (!run_reg) begin
          state_next = RSWS_IDLE;
        end else if (olsw_reg) begin
          state_next = RSWS_OPEN; // R10
        end else if (slp_exp) begin
          state_next = RSWS_SLEEP; // R5
          events[IRQ_SLEEP_BIT] = 1'b1;
        end
      end
      RSWS_SLEEP: begin
        if (!run_reg) begin
          state_next = RSWS_IDLE;
        end else if (olsw_reg) begin
          state_next = RSWS_OPEN;
        end else if (wake) begin
          state_next = RSWS_REG;
          events[IRQ_WAKE_BIT] = 1'b1;
        end
      end
      RSWS_OPEN: begin
        if (!run_reg) begin
          state_next = RSWS_IDLE;
        end else if (!olsw_reg) begin
          // Pre-regulation is finished only once feedback got there
          state_next = regulating_reg ? RSWS_REG : RSWS_PRE; // R11
        end
      end
      RSWS_TRIP: begin
        if (fault_clr && !run_reg) begin
          state_next = RSWS_IDLE;
        end
      end
      default: state_next = RSWS_IDLE;
    endcase
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      state_reg      <= RSWS_IDLE;
      regulating_reg <= 1'b0;
    end else begin
      state_reg      <= state_next;
      regulating_reg <= regulating_next;
    end
  end

  logic             reg_en_reg, ol_en_reg, block_reg, trip_reg, slp_reg;
  logic [VAL_W-1:0] target_reg;

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      reg_en_reg <= 1'b0;
      ol_en_reg  <= 1'b0;
      block_reg  <= 1'b1;
      trip_reg   <= 1'b0;
      slp_reg    <= 1'b0;
      target_reg <= '0;
    end else begin
      reg_en_reg <= (state_next == RSWS_REG);
      ol_en_reg  <= (state_next == RSWS_PRE) ||
                    (state_next == RSWS_OPEN); // R2 R10
      block_reg  <= (state_next == RSWS_TRIP) ||
                    (state_next == RSWS_SLEEP) ||
                    (state_next == RSWS_IDLE); // R4 R5
      trip_reg   <= (state_next == RSWS_TRIP);
      slp_reg    <= (state_next == RSWS_SLEEP); // R6
      target_reg <= (state_next == RSWS_PRE) ? prefreq_reg : '0; // R1
    end
  end

  assign REGULATION_EN               = reg_en_reg;
  assign OPEN_LOOP_EN                = ol_en_reg;
  assign OUTPUT_BLOCK                = block_reg;
  assign PRE_REGULATION_FAILURE_TRIP = trip_reg;
  assign SLEEP_WARNING               = slp_reg;
  assign OPEN_LOOP_TARGET            = target_reg;
endmodule
`default_nettype wire

// ===== inc/rsws_pkg.sv
// Constants, register map and state codes for the regulator sleep/wake
// sequencer. Assumes a 25 MHz control clock and a 32-bit APB slave.
// Summary of operation
// [R1] Run command before regulation starts: accelerate open loop to pre-regulation frequency.
// [R2] Stay open loop while feedback has not exceeded the exit level.
// [R3] Feedback above exit level: leave pre-regulation and start closed-loop regulation.
// [R4] Nonzero fail delay and feedback low for it: failure trip, output blocked.
// [R5] Output frequency below sleep threshold for sleep delay: stop output, sleep.
// [R6] Entering sleep raises a non-latching sleep warning.
// [R7] Wake mode 0: wake when feedback below wake level.
// [R8] Wake mode 1: wake when feedback above wake level.
// [R9] Wake mode 2: wake when reference minus feedback exceeds wake level.
// [R10] Open-loop switch input active: suspend regulation, run ordinary frequency control.
// [R11] Open-loop switch released: resume closed-loop regulation; code goes back to pre-regulation if not yet regulating.
// [R12] Delay timers restart from zero whenever their condition breaks.
// [R13] Open-loop switch active suppresses sleep entry and failure check.
`default_nettype none
package rsws_pkg;
  localparam int VAL_W = 16;
  localparam int DLY_W = 16;
  localparam int CLK_HZ = 25_000_000;
  // Delays are programmed in milliseconds
  localparam int TICK_MS = 1;
  localparam int TICK_CYC = CLK_HZ / 1000 * TICK_MS;
  localparam int TICK_W = 15;

  localparam logic [11:0] CTRL_OFS     = 12'h000;
  localparam logic [11:0] PREFREQ_OFS  = 12'h004;
  localparam logic [11:0] PREEXIT_OFS  = 12'h008;
  localparam logic [11:0] PREDLY_OFS   = 12'h00C;
  localparam logic [11:0] SLPDLY_OFS   = 12'h010;
  localparam logic [11:0] SLPFREQ_OFS  = 12'h014;
  localparam logic [11:0] WAKELEV_OFS  = 12'h018;
  localparam logic [11:0] STATE_OFS    = 12'h01C;
  localparam logic [11:0] IRQ_STAT_OFS = 12'h020;
  localparam logic [11:0] IRQ_MASK_OFS = 12'h024;

  // CTRL fields
  localparam int CTRL_WMODE_LSB = 0;
  localparam int CTRL_FCLR_BIT  = 4;
  localparam logic [1:0] WAKE_BELOW  = 2'h0;
  localparam logic [1:0] WAKE_ABOVE  = 2'h1;
  localparam logic [1:0] WAKE_BEYOND = 2'h2;

  // Interrupt status bits
  localparam int IRQ_TRIP_BIT  = 0;
  localparam int IRQ_SLEEP_BIT = 1;
  localparam int IRQ_WAKE_BIT  = 2;
  localparam int IRQ_W = 3;

  localparam logic [VAL_W-1:0] PREFREQ_RST = 16'h0000;
  localparam logic [VAL_W-1:0] PREEXIT_RST = 16'h0000;
  localparam logic [DLY_W-1:0] PREDLY_RST  = 16'h0000;
  localparam logic [DLY_W-1:0] SLPDLY_RST  = 16'h0000;
  localparam logic [VAL_W-1:0] SLPFREQ_RST = 16'h0000;
  localparam logic [VAL_W-1:0] WAKELEV_RST = 16'h0000;

  typedef enum logic [5:0] {
    RSWS_IDLE  = 6'h01,
    RSWS_PRE   = 6'h02,
    RSWS_REG   = 6'h04,
    RSWS_SLEEP = 6'h08,
    RSWS_OPEN  = 6'h10,
    RSWS_TRIP  = 6'h20
  } rsws_state_t;
endpackage
`default_nettype wire

// ===== design/rsws_timer.sv
// Millisecond interval timer: counts uninterrupted qualifying time.
// Assumes a shared one-cycle millisecond tick on the same clock.
`timescale 1ns/1ps
`default_nettype none
module rsws_timer
  import rsws_pkg::*;
(
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             tick,
  input  wire logic             run,
  input  wire logic [DLY_W-1:0] limit,
  output logic                  expired
);
  logic [DLY_W-1:0] cnt_reg;
  logic [DLY_W-1:0] cnt_next;

  always_comb begin
    cnt_next = cnt_reg;
    if (!run) begin
      cnt_next = '0; // R12
    end else if (tick && cnt_reg != limit) begin
      cnt_next = cnt_reg + 16'h0001;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cnt_reg <= '0;
    end else begin
      cnt_reg <= cnt_next;
    end
  end

  assign expired = run && (cnt_reg == limit);
endmodule
`default_nettype wire

// ===== dv/rsws_properties.sv
// Concurrent checks on the sequencer outputs.
// Assumes a bind onto rsws_top; sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module rsws_properties
  import rsws_pkg::*;
(
  input wire logic        CLK,
  input wire logic        RST_N,
  input wire logic        PSEL,
  input wire logic        PENABLE,
  input wire logic        PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [31:0] PRDATA,
  input wire logic        PREADY,
  input wire logic        PSLVERR,
  input wire logic        RUN_CMD,
  input wire logic        OPEN_LOOP_SWITCH,
  input wire logic [15:0] FEEDBACK,
  input wire logic [15:0] REFERENCE,
  input wire logic [15:0] OUTPUT_FREQ,
  input wire logic        REGULATION_EN,
  input wire logic        OPEN_LOOP_EN,
  input wire logic [15:0] OPEN_LOOP_TARGET,
  input wire logic        OUTPUT_BLOCK,
  input wire logic        PRE_REGULATION_FAILURE_TRIP,
  input wire logic        SLEEP_WARNING,
  input wire logic        IRQ
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_N);
  // Eight edges covers the pin synchroniser plus the state register
  sequence s_open_run;
    (RUN_CMD && OPEN_LOOP_SWITCH && !PRE_REGULATION_FAILURE_TRIP)[*8];
  endsequence
  sequence s_run_off;
    (!RUN_CMD)[*8];
  endsequence
  AST_TRIP_BLOCK: assert property (
    PRE_REGULATION_FAILURE_TRIP |-> OUTPUT_BLOCK && !REGULATION_EN)
    else $error("trip without output block");
  AST_SLEEP_BLOCK: assert property (
    SLEEP_WARNING |-> OUTPUT_BLOCK && !REGULATION_EN
      && !OPEN_LOOP_EN && !PRE_REGULATION_FAILURE_TRIP)
    else $error("sleep while output live");
  AST_MODE_EXCL: assert property (
    !(REGULATION_EN && OPEN_LOOP_EN))
    else $error("regulation and open loop together");
  AST_OPEN_HOLD: assert property (
    s_open_run ##1 s_open_run |->
      OPEN_LOOP_EN && !REGULATION_EN && !SLEEP_WARNING)
    else $error("open-loop switch not obeyed");
  AST_TARGET: assert property (
    !OPEN_LOOP_EN |-> OPEN_LOOP_TARGET == 16'h0000)
    else $error("target outside open loop");
  AST_RUN_DROP: assert property (
    s_run_off |-> OUTPUT_BLOCK && !REGULATION_EN && !OPEN_LOOP_EN)
    else $error("running without run command");
  AST_SLEEP_ENTRY: assert property (
    $rose(SLEEP_WARNING) |-> $past(REGULATION_EN))
    else $error("sleep entered outside regulation");
  AST_TRIP_ENTRY: assert property (
    $rose(PRE_REGULATION_FAILURE_TRIP) |-> $past(OPEN_LOOP_EN))
    else $error("trip outside pre-regulation");
endmodule
`default_nettype wire

// ===== dv/rsws_field.sv
// Process side model: sensor words and the open-loop terminal.
// Assumes the bench commands levels; they land one edge later.
`timescale 1ns/1ps
`default_nettype none
module rsws_field
  import rsws_pkg::*;
(
  input  wire logic             clk,
  input  wire logic [VAL_W-1:0] fb_cmd,
  input  wire logic [VAL_W-1:0] ref_cmd,
  input  wire logic [VAL_W-1:0] frq_cmd,
  input  wire logic             sw_cmd,
  output logic      [VAL_W-1:0] feedback,
  output logic      [VAL_W-1:0] reference,
  output logic      [VAL_W-1:0] output_freq,
  output logic                  open_loop_switch
);
  // Sampled like a converter, so words never change off the edge
  always @(posedge clk) begin
    feedback <= fb_cmd;
    reference <= ref_cmd;
    output_freq <= frq_cmd;
    open_loop_switch <= sw_cmd;
  end
endmodule
`default_nettype wire

// ===== dv/rsws_top_tb.sv
// Self-checking bench for the sleep/wake sequencer.
// Assumes zero-wait APB and 25000-cycle millisecond ticks.
`timescale 1ns/1ps
`default_nettype none
module rsws_top_tb;
  import rsws_pkg::*;
  logic CLK = 1'b0, RST_N = 1'b0, PSEL = 1'b0, PENABLE = 1'b0;
  logic PWRITE = 1'b0, RUN_CMD = 1'b0, sw_cmd = 1'b0, rerr;
  logic [11:0] PADDR = 12'h000;
  logic [31:0] PWDATA = 32'h0, PRDATA, rdat;
  logic PREADY, PSLVERR, OPEN_LOOP_SWITCH, REGULATION_EN, OPEN_LOOP_EN;
  logic OUTPUT_BLOCK, PRE_REGULATION_FAILURE_TRIP, SLEEP_WARNING, IRQ;
  logic [VAL_W-1:0] FEEDBACK, REFERENCE, OUTPUT_FREQ, OPEN_LOOP_TARGET;
  logic [VAL_W-1:0] fb_cmd = 16'h0000, ref_cmd = 16'h0800;
  logic [VAL_W-1:0] frq_cmd = 16'hFFFF;
  int miscompares = 0, check_count = 0, cycles = 0;
  always #20 CLK = ~CLK;
  rsws_top rsws_top_inst (.*);
  rsws_field rsws_field_inst (.clk(CLK), .fb_cmd(fb_cmd),
    .ref_cmd(ref_cmd), .frq_cmd(frq_cmd), .sw_cmd(sw_cmd),
    .feedback(FEEDBACK), .reference(REFERENCE),
    .output_freq(OUTPUT_FREQ), .open_loop_switch(OPEN_LOOP_SWITCH));
  task automatic results;
    if (miscompares == 0 && check_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e) begin
      miscompares++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge CLK);
    PSEL <= 1'b1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge CLK);
    PENABLE <= 1'b1;
    do @(posedge CLK); while (PREADY !== 1'b1);
    rerr = PSLVERR;
    rdat = PRDATA;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
    // One idle edge lets a written value reach the outputs before checks
    @(posedge CLK);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rdat, e);
  endtask
  function automatic logic pick(input int k);
    case (k)
      0: return REGULATION_EN;
      1: return OPEN_LOOP_EN;
      2: return SLEEP_WARNING;
      default: return PRE_REGULATION_FAILURE_TRIP;
    endcase
  endfunction
  task automatic wait_for(input int k, input int lim);
    int n;
    n = 0;
    while (pick(k) !== 1'b1 && n < lim) begin
      @(posedge CLK);
      n++;
    end
    chk({31'h0, pick(k)}, 32'h1);
  endtask
  task automatic t_pre_reg;
    rd(STATE_OFS, 32'h01);
    apb(1'b1, PREFREQ_OFS, 32'h1234);
    rd(PREFREQ_OFS, 32'h1234);
    rd(12'h03C, 32'h0);
    chk(rerr, 1);
    apb(1'b1, PREEXIT_OFS, 32'h0100);
    fb_cmd <= 16'h0100;
    RUN_CMD <= 1'b1;
    wait_for(1, 20);
    repeat (20) @(posedge CLK);
    chk(OPEN_LOOP_TARGET, 32'h1234);
    chk(REGULATION_EN, 0);
    rd(STATE_OFS, 32'h02);
    fb_cmd <= 16'h0101;
    wait_for(0, 20);
    chk(OPEN_LOOP_EN, 0);
  endtask
  task automatic t_open;
    apb(1'b1, SLPFREQ_OFS, 32'h0200);
    sw_cmd <= 1'b1;
    wait_for(1, 20);
    // Slow output only once the switch is through its synchroniser
    frq_cmd <= 16'h0000;
    repeat (20) @(posedge CLK);
    chk(REGULATION_EN, 0);
    chk(SLEEP_WARNING, 0);
    rd(IRQ_STAT_OFS, 32'h0);
    frq_cmd <= 16'hFFFF;
    sw_cmd <= 1'b0;
    wait_for(0, 20);
  endtask
  task automatic t_sleep_wake;
    apb(1'b1, WAKELEV_OFS, 32'h0400);
    apb(1'b1, IRQ_MASK_OFS, 32'h6);
    for (int m = 0; m < 3; m++) begin
      apb(1'b1, CTRL_OFS, 32'(m));
      // Feedback on the wake level never wakes: comparisons are strict
      fb_cmd <= 16'h0400;
      frq_cmd <= 16'h0100;
      wait_for(2, 20);
      repeat (20) @(posedge CLK);
      chk(OUTPUT_BLOCK, 1);
      chk(SLEEP_WARNING, 1);
      chk(IRQ, 1);
      rd(IRQ_STAT_OFS, 32'h2);
      chk(IRQ, 0);
      frq_cmd <= 16'hFFFF;
      fb_cmd <= (m == 1) ? 16'h0401 : 16'h03FF;
      wait_for(0, 20);
      chk(SLEEP_WARNING, 0);
      chk(IRQ, 1);
      rd(IRQ_STAT_OFS, 32'h4);
    end
  endtask
  task automatic t_trip;
    RUN_CMD <= 1'b0;
    repeat (10) @(posedge CLK);
    chk(OUTPUT_BLOCK, 1);
    apb(1'b1, PREDLY_OFS, 32'h2);
    fb_cmd <= 16'h0000;
    RUN_CMD <= 1'b1;
    wait_for(1, 20);
    // A break after the first tick must cost the timer its count
    // Ticks come every 25000 cycles, so 25010 lies past the first one
    repeat (25010) @(posedge CLK);
    sw_cmd <= 1'b1;
    repeat (20) @(posedge CLK);
    sw_cmd <= 1'b0;
    repeat (25070) @(posedge CLK);
    chk(PRE_REGULATION_FAILURE_TRIP, 0);
    wait_for(3, 26000);
    chk(OUTPUT_BLOCK, 1);
    chk(IRQ, 0);
    apb(1'b1, IRQ_MASK_OFS, 32'h7);
    chk(IRQ, 1);
    rd(IRQ_STAT_OFS, 32'h1);
    RUN_CMD <= 1'b0;
    repeat (10) @(posedge CLK);
    apb(1'b1, CTRL_OFS, 32'h10);
    repeat (2) @(posedge CLK);
    chk(PRE_REGULATION_FAILURE_TRIP, 0);
  endtask
  always @(posedge CLK) begin
    cycles++;
    if (cycles == 90000) begin
      miscompares++;
      results();
    end
  end
  initial begin
    repeat (6) @(posedge CLK);
    RST_N <= 1'b1;
    t_pre_reg();
    t_open();
    t_sleep_wake();
    t_trip();
    results();
  end
endmodule
bind rsws_top rsws_properties rsws_properties_inst (.*);
`default_nettype wire
